// >>> core/fsr_pkg.sv
// Constants and types shared by the serial status-register front end
package fsr_pkg;

  // Clock of the block, in nanoseconds
  localparam int CLK_PERIOD_NS = 25;

  // Command codes seen on the serial input
  localparam logic [7:0] CMD_PD_EXIT = 8'hAB; // Leave power-down / id read
  localparam logic [7:0] CMD_PD_ENTER = 8'hB9; // Enter power-down
  localparam logic [7:0] CMD_WREN = 8'h06; // Write enable, both copies
  localparam logic [7:0] CMD_VWREN = 8'h50; // Write enable, volatile only
  localparam logic [7:0] CMD_RD_SR1 = 8'h05;
  localparam logic [7:0] CMD_RD_SR2 = 8'h35;
  localparam logic [7:0] CMD_RD_SR3 = 8'h15;
  localparam logic [7:0] CMD_WR_SR1 = 8'h01;
  localparam logic [7:0] CMD_WR_SR2 = 8'h31;
  localparam logic [7:0] CMD_WR_SR3 = 8'h11;
  localparam logic [7:0] CMD_RD_IND = 8'h65; // Indirect status read
  localparam logic [7:0] CMD_WR_IND = 8'h71; // Indirect status write

  // Indirect addresses of the five status registers
  localparam logic [7:0] ADDR_SR_ONE = 8'h01;
  localparam logic [7:0] ADDR_SR_TWO = 8'h02;
  localparam logic [7:0] ADDR_SR_THREE = 8'h03;
  localparam logic [7:0] ADDR_SR_FOUR = 8'h04;
  localparam logic [7:0] ADDR_SR_FIVE = 8'h05;

  // Field positions
  localparam int HOLD_ROLE_BIT = 7; // Status reg three: 1 = reset role
  localparam int QUAD_ENABLE_BIT = 1; // Status reg two: quad_enable_bit
  localparam int BUSY_BIT = 0; // Status reg one, live
  localparam int WEL_BIT = 1; // Status reg one, live

  // Stored copy after power-up, registers five..one
  localparam logic [39:0] NV_DEFAULT = 40'h00_0000_0000;

  // Identifier byte returned by the power-down exit command (arbitrary)
  localparam logic [7:0] ID_CODE = 8'h5A;

  // Stored-copy write time, then its cycle count
  localparam int T_NVW_NS = 2000;
  localparam logic [7:0] NVW_CYCLES = 8'(T_NVW_NS / CLK_PERIOD_NS);

  // Frame counters
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] MAX_BYTES = 3'h7; // Byte count saturates here
  localparam logic [2:0] ID_BYTES = 3'h5; // Command, three dummy, id

  // Top-level states, one-hot
  typedef enum logic [2:0] {
    ST_LOAD = 3'h1, // Copy stored values into the flip-flops
    ST_RUN = 3'h2, // Normal serial operation
    ST_RST = 3'h4 // Held in reset by the shared pin
  } fsr_st_t;

  // Whole state of the block
  typedef struct packed {
    fsr_st_t st;
    logic sclk_s1, sclk_s2, sclk_d;
    logic cs_s1, cs_s2, cs_d;
    logic si_s1, si_s2;
    logic pin_s1, pin_s2;
    logic [4:0][7:0] vol; // Flip-flop status registers
    logic [4:0][7:0] nv; // Stored copy
    logic [2:0] bit_idx;
    logic [2:0] byte_cnt;
    logic [7:0] sh;
    logic [7:0] cmd;
    logic [7:0] d1;
    logic [7:0] d2;
    logic [7:0] out_sh;
    logic out_act;
    logic so;
    logic so_oe;
    logic paused;
    logic pd;
    logic wel;
    logic vwel;
    logic [7:0] busy_cnt;
  } fsr_state_t;

endpackage : fsr_pkg

// >>> core/fsr_core.sv
// Serial front end: framing, pause/reset pin and five status registers
`timescale 1ns/10ps

module fsr_core
  import fsr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i, // Serial clock from the host
  input wire logic cs_n_i, // Chip select, active low
  input wire logic si_i, // Serial data in
  input wire logic hold_reset_n_i, // Shared pin level
  output logic data_line_three_o, // Shared pin drive value
  output logic data_line_three_oe_o, // Shared pin drive enable
  output logic so_o, // Serial data out
  output logic so_oe_o, // Serial out drive enable
  output logic paused_o, // Pause in effect
  output logic power_down_o, // Power-down mode
  output logic in_reset_o // Held in reset by the shared pin
);

  // Registered state and its next value
  fsr_state_t s_reg;
  fsr_state_t s_next;

  // Edges and pin roles seen by the logic
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic hold_act;
  logic rst_act;
  logic [7:0] new_byte;

  // Direct read command to register address, zero if none
  function automatic logic [7:0] rd_addr(input logic [7:0] c);
    case (c)
      CMD_RD_SR1: rd_addr = ADDR_SR_ONE;
      CMD_RD_SR2: rd_addr = ADDR_SR_TWO;
      CMD_RD_SR3: rd_addr = ADDR_SR_THREE;
      default: rd_addr = 8'h00; // No direct path to four, five
    endcase
  endfunction : rd_addr

  // Direct write command to register address, zero if none
  function automatic logic [7:0] wr_addr(input logic [7:0] c);
    case (c)
      CMD_WR_SR1: wr_addr = ADDR_SR_ONE;
      CMD_WR_SR2: wr_addr = ADDR_SR_TWO;
      CMD_WR_SR3: wr_addr = ADDR_SR_THREE;
      default: wr_addr = 8'h00;
    endcase
  endfunction : wr_addr

  // Address in range one to five
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a >= ADDR_SR_ONE) && (a <= ADDR_SR_FIVE);
  endfunction : addr_ok

  // Register read; busy and enable show live in register one
  function automatic logic [7:0] sr_read(input logic [4:0][7:0] v,
                                         input logic [7:0] a,
                                         input logic busy,
                                         input logic wel);
    logic [7:0] val;
    val = 8'h00;
    if (addr_ok(a)) begin
      val = v[a[2:0] - 3'h1];
    end
    if (a == ADDR_SR_ONE) begin
      val[BUSY_BIT] = busy;
      val[WEL_BIT] = wel;
    end
    sr_read = val; // Out of range reads zero
  endfunction : sr_read

  // Edge detect on the second synchroniser stage only
  assign sclk_rise = s_reg.sclk_s2 & ~s_reg.sclk_d;
  assign sclk_fall = ~s_reg.sclk_s2 & s_reg.sclk_d;
  assign cs_rise = s_reg.cs_s2 & ~s_reg.cs_d;
  assign new_byte = {s_reg.sh[6:0], s_reg.si_s2};
  // Pin role: quad mode turns both roles off
  assign hold_act = ~s_reg.vol[2][HOLD_ROLE_BIT] &
                    ~s_reg.vol[1][QUAD_ENABLE_BIT] & ~s_reg.pin_s2;
  assign rst_act = s_reg.vol[2][HOLD_ROLE_BIT] &
                   ~s_reg.vol[1][QUAD_ENABLE_BIT] & ~s_reg.pin_s2;

  // Next-state logic
  always_comb begin
    logic wr_go;
    logic [2:0] wr_idx;
    logic [7:0] wr_data;
    logic [7:0] c;
    logic [7:0] a;
    logic [2:0] nc;
    wr_go = 1'b0;
    wr_idx = 3'h0;
    wr_data = 8'h00;
    c = 8'h00;
    a = 8'h00;
    nc = 3'h0;
    s_next = s_reg;
    // Two-stage synchronisers for every pin
    s_next.sclk_s1 = sclk_i;
    s_next.sclk_s2 = s_reg.sclk_s1;
    s_next.sclk_d = s_reg.sclk_s2;
    s_next.cs_s1 = cs_n_i;
    s_next.cs_s2 = s_reg.cs_s1;
    s_next.cs_d = s_reg.cs_s2;
    s_next.si_s1 = si_i;
    s_next.si_s2 = s_reg.si_s1;
    s_next.pin_s1 = hold_reset_n_i;
    s_next.pin_s2 = s_reg.pin_s1;
    // Stored-copy write timer
    if (s_reg.busy_cnt != 8'h00) begin
      s_next.busy_cnt = s_reg.busy_cnt - 8'h01;
    end
    case (s_reg.st)
      ST_LOAD: begin
        // Power-up copy into the flip-flops
        s_next.vol = s_reg.nv;
        s_next.st = ST_RUN;
      end
      ST_RST: begin
        // Flip-flops lose their contents and reload; no frame runs
        s_next.vol = s_reg.nv;
        s_next.bit_idx = 3'h0;
        s_next.byte_cnt = 3'h0;
        s_next.out_act = 1'b0;
        s_next.so_oe = 1'b0;
        s_next.paused = 1'b0;
        s_next.pd = 1'b0;
        s_next.wel = 1'b0;
        s_next.vwel = 1'b0;
        if (s_reg.pin_s2) begin
          s_next.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (rst_act) begin
          // Pin reset drops the frame in flight
          s_next.st = ST_RST;
          s_next.so_oe = 1'b0;
          s_next.out_act = 1'b0;
        end else if (s_reg.cs_s2) begin
          // Deselected: commands take effect on the rising select
          if (cs_rise && s_reg.bit_idx == 3'h0) begin
            case (s_reg.cmd)
              CMD_PD_EXIT: begin
                // Bare command or a complete id read
                if (s_reg.byte_cnt == 3'h1 ||
                    s_reg.byte_cnt >= ID_BYTES) begin
                  s_next.pd = 1'b0;
                end
              end
              CMD_PD_ENTER: begin
                if (s_reg.byte_cnt == 3'h1) begin
                  s_next.pd = 1'b1;
                end
              end
              CMD_WREN: begin
                if (s_reg.byte_cnt == 3'h1 && !s_reg.pd) begin
                  s_next.wel = 1'b1;
                  s_next.vwel = 1'b0;
                end
              end
              CMD_VWREN: begin
                if (s_reg.byte_cnt == 3'h1 && !s_reg.pd) begin
                  s_next.vwel = 1'b1;
                  s_next.wel = 1'b0;
                end
              end
              CMD_WR_IND: begin
                // Address byte then data byte
                if (s_reg.byte_cnt == 3'h3 && addr_ok(s_reg.d1)) begin
                  wr_go = 1'b1;
                  wr_idx = s_reg.d1[2:0] - 3'h1;
                  wr_data = s_reg.d2;
                end
              end
              default: begin
                a = wr_addr(s_reg.cmd); // Direct write target, if any
                if (a != 8'h00 && s_reg.byte_cnt == 3'h2) begin
                  wr_go = 1'b1;
                  wr_idx = a[2:0] - 3'h1;
                  wr_data = s_reg.d1;
                end
              end
            endcase
          end
          // Select high ends any pause
          s_next.bit_idx = 3'h0;
          s_next.byte_cnt = 3'h0;
          s_next.out_act = 1'b0;
          s_next.so_oe = 1'b0;
          s_next.paused = 1'b0;
        end else begin
          // Pause follows the pin only at falling clock edges
          if (sclk_fall) begin
            s_next.paused = hold_act;
            if (hold_act) begin
              s_next.so_oe = 1'b0;
            end else if (s_reg.out_act) begin
              // Mode 0: next bit goes out on the falling edge; the edge
              // that ends a pause shifts too, standing in for the one
              // swallowed when the pause began, so no bit repeats
              s_next.so = s_reg.out_sh[7];
              s_next.out_sh = {s_reg.out_sh[6:0], 1'b0};
              s_next.so_oe = 1'b1;
            end
          end
          // Input bits are taken on rising edges unless paused
          if (sclk_rise && !s_reg.paused) begin
            s_next.sh = new_byte;
            s_next.bit_idx = s_reg.bit_idx + 3'h1;
            if (s_reg.bit_idx == LAST_BIT) begin
              nc = (s_reg.byte_cnt == MAX_BYTES) ? s_reg.byte_cnt :
                   s_reg.byte_cnt + 3'h1;
              s_next.byte_cnt = nc;
              c = (s_reg.byte_cnt == 3'h0) ? new_byte : s_reg.cmd;
              case (s_reg.byte_cnt)
                3'h0: s_next.cmd = new_byte;
                3'h1: s_next.d1 = new_byte;
                3'h2: s_next.d2 = new_byte;
                default: s_next.d2 = s_reg.d2;
              endcase
              // Load the next output byte; repeats until select rises
              if (s_reg.pd && c != CMD_PD_EXIT) begin
                s_next.out_act = 1'b0; // Sleeping: only wake command
              end else if (rd_addr(c) != 8'h00) begin
                s_next.out_act = 1'b1;
                s_next.out_sh = sr_read(s_reg.vol, rd_addr(c),
                                        s_reg.busy_cnt != 8'h00,
                                        s_reg.wel | s_reg.vwel);
              end else if (c == CMD_RD_IND && nc >= 3'h2) begin
                a = (nc == 3'h2) ? new_byte : s_reg.d1;
                s_next.out_act = 1'b1;
                s_next.out_sh = sr_read(s_reg.vol, a,
                                        s_reg.busy_cnt != 8'h00,
                                        s_reg.wel | s_reg.vwel);
              end else if (c == CMD_PD_EXIT && nc >= 3'h4) begin
                // Id goes out in clocks 33 to 40
                s_next.out_act = 1'b1;
                s_next.out_sh = ID_CODE;
              end
            end
          end
        end
      end
      default: s_next.st = ST_LOAD;
    endcase
    // Status write; busy rejects a second stored-copy write
    if (wr_go && (s_reg.wel || s_reg.vwel) && !s_reg.pd &&
        s_reg.busy_cnt == 8'h00) begin
      s_next.vol[wr_idx] = wr_data;
      if (s_reg.wel) begin
        s_next.nv[wr_idx] = wr_data;
        s_next.busy_cnt = NVW_CYCLES;
      end
      s_next.wel = 1'b0;
      s_next.vwel = 1'b0;
    end
  end

  // State register; stored copy starts from its power-up value
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.st <= ST_LOAD;
      s_reg.nv <= NV_DEFAULT;
      s_reg.cs_s1 <= 1'b1;
      s_reg.cs_s2 <= 1'b1;
      s_reg.cs_d <= 1'b1;
      s_reg.pin_s1 <= 1'b1;
      s_reg.pin_s2 <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state; this port only drives single SPI
  assign so_o = s_reg.so;
  assign so_oe_o = s_reg.so_oe;
  assign paused_o = s_reg.paused;
  assign power_down_o = s_reg.pd;
  assign in_reset_o = s_reg.st[2];
  assign data_line_three_o = s_reg.sh[0] & 1'b0;
  assign data_line_three_oe_o = s_reg.out_act & 1'b0;

  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_whole_end;
    s_reg.st == ST_RUN && !rst_act && cs_rise && s_reg.bit_idx == 3'h0;
  endsequence
  sequence s_odd_end;
    s_reg.st == ST_RUN && !rst_act && cs_rise && s_reg.bit_idx != 3'h0;
  endsequence
  sequence s_take_byte;
    s_reg.st == ST_RUN && !rst_act && !s_reg.cs_s2 && sclk_rise &&
    !s_reg.paused && s_reg.bit_idx == LAST_BIT;
  endsequence

  a_odd_frame_drop: assert property (
    s_odd_end |=> $stable(s_reg.vol) && $stable(s_reg.pd) &&
                  $stable(s_reg.wel) && $stable(s_reg.vwel))
    else $error("odd frame changed state");
  a_pd_exit_cmd: assert property (
    s_whole_end ##0 (s_reg.cmd == CMD_PD_EXIT && s_reg.byte_cnt == 3'h1)
    |=> !s_reg.pd) else $error("power-down exit not taken");
  a_id_out_byte: assert property (
    s_take_byte ##0 (s_reg.cmd == CMD_PD_EXIT && s_reg.byte_cnt == 3'h3)
    |=> s_reg.out_act && s_reg.out_sh == ID_CODE)
    else $error("id byte not loaded");
  a_id_pd_exit: assert property (
    s_whole_end ##0 (s_reg.cmd == CMD_PD_EXIT && s_reg.byte_cnt == 3'h5)
    |=> !s_reg.pd) else $error("id read did not exit power-down");
  a_id_pd_keep: assert property (
    s_odd_end ##0 (s_reg.cmd == CMD_PD_EXIT && s_reg.pd) |=> s_reg.pd)
    else $error("odd id read left power-down");
  a_reset_role: assert property (
    (s_reg.st == ST_RUN && rst_act) |=> s_reg.st == ST_RST ##1
    (s_reg.st == ST_RST || s_reg.pin_s2))
    else $error("pin reset not entered");
  a_quad_no_pause: assert property (
    (s_reg.vol[1][QUAD_ENABLE_BIT] && s_reg.st == ST_RUN && sclk_fall &&
     !s_reg.cs_s2) |=> !s_reg.paused && s_reg.st == ST_RUN)
    else $error("quad mode paused or reset");
  a_reset_refuse: assert property (
    s_reg.st == ST_RST |=> s_reg.byte_cnt == 3'h0 && !s_reg.so_oe &&
    $stable(s_reg.nv)) else $error("command taken in reset");
  a_pause_enter: assert property (
    (s_reg.st == ST_RUN && !s_reg.cs_s2 && !rst_act && sclk_fall &&
     hold_act) |=> s_reg.paused [*1] ##1 (s_reg.paused || sclk_fall ||
     s_reg.cs_s2 || s_reg.st != ST_RUN))
    else $error("pause not entered");
  a_pause_quiet: assert property (
    (s_reg.paused && !s_reg.cs_s2 && s_reg.st == ST_RUN && !rst_act &&
     !sclk_fall) |=> !s_reg.so_oe && $stable(s_reg.bit_idx))
    else $error("paused device active");
  a_load_copy: assert property (
    s_reg.st == ST_LOAD |=> s_reg.vol == $past(s_reg.nv))
    else $error("power-up copy missing");
  a_vol_only: assert property (
    s_whole_end ##0 (s_reg.cmd == CMD_WR_SR2 && s_reg.byte_cnt == 3'h2 &&
    s_reg.vwel && !s_reg.pd && s_reg.busy_cnt == 8'h00)
    |=> s_reg.vol[1] == $past(s_reg.d1) && $stable(s_reg.nv) &&
        s_reg.busy_cnt == 8'h00) else $error("volatile write wrong");
  a_nv_write: assert property (
    s_whole_end ##0 (s_reg.cmd == CMD_WR_IND && s_reg.byte_cnt == 3'h3 &&
    s_reg.d1 == ADDR_SR_FIVE && s_reg.wel && !s_reg.pd &&
    s_reg.busy_cnt == 8'h00) |=> s_reg.nv[4] == $past(s_reg.d2) &&
    s_reg.vol[4] == $past(s_reg.d2) && s_reg.busy_cnt == NVW_CYCLES)
    else $error("stored write wrong");
  a_bad_addr: assert property (
    s_whole_end ##0 (s_reg.cmd == CMD_WR_IND && s_reg.byte_cnt == 3'h3 &&
    !addr_ok(s_reg.d1)) |=> $stable(s_reg.vol) && $stable(s_reg.nv))
    else $error("bad address wrote");

endmodule : fsr_core

// >>> bench/fsr_host.sv
// Host-side model of the serial link: select, clock, data and shared pin
`timescale 1ns/10ps
module fsr_host (
  input wire logic clk_i,
  input wire logic so_i, // Serial data from the device
  input wire logic so_oe_i, // Device drives serial data
  input wire logic paused_i, // Device pause flag
  output logic sclk_o, // Mode 0: idles low between frames
  output logic cs_n_o, // Chip select, active low
  output logic si_o, // Serial data to the device
  output logic pin_n_o // Shared pause/reset pin
);
  logic oe_seen; // Device drove serial out in the last frame
  logic pause_seen; // Pause flag up with output released
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    pin_n_o = 1'b1;
    oe_seen = 1'b0;
    pause_seen = 1'b0;
  end
  // Step a few clocks, changing nothing on the edge itself
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_i);
      #1;
      if (!cs_n_o && so_oe_i === 1'b1) begin
        oe_seen = 1'b1;
      end
    end
  endtask : tick
  // One frame of n bits, MSB first; optional pause after bit p
  task automatic frame(input logic [63:0] tx, input int n, input int p,
                       output logic [63:0] rx);
    rx = '0;
    oe_seen = 1'b0;
    pause_seen = 1'b0;
    cs_n_o = 1'b0;
    tick(4);
    for (int i = 0; i < n; i++) begin // n clocks, plus two more inside a pause
      sclk_o = 1'b0;
      si_o = tx[n-1-i];
      tick(4);
      sclk_o = 1'b1;
      tick(4);
      // Undriven output reads as the inverse of its last level
      rx = {rx[62:0], (so_oe_i === 1'b1) ? so_i : ~so_i};
      if (i + 1 == p) begin // Select stays low all pause
        pin_n_o = 1'b0;
        tick(3);
        sclk_o = 1'b0;
        si_o = ~si_o;
        tick(4);
        // Clock and data keep moving; the device must ignore them
        sclk_o = 1'b1;
        tick(2);
        pause_seen = (paused_i === 1'b1) && (so_oe_i === 1'b0);
        tick(2);
        sclk_o = 1'b0;
        si_o = ~si_o;
        tick(4);
        sclk_o = 1'b1;
        tick(2);
        pin_n_o = 1'b1;
        tick(3);
      end
    end
    sclk_o = 1'b0;
    tick(4);
    cs_n_o = 1'b1;
    // Released data line must not look like the last bit
    si_o = ~si_o;
    tick(6);
  endtask : frame
  // Drive the shared pin with select high and let it settle
  task automatic set_pin(input logic lvl);
    pin_n_o = lvl;
    tick(6);
  endtask : set_pin
endmodule : fsr_host

// >>> bench/tb_flash_spi_frame_hold_status_access.sv
// Self-checking bench for the serial status-register front end
`timescale 1ns/10ps
module tb_flash_spi_frame_hold_status_access
  import fsr_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sclk, cs_n, si, pin_n, so, so_oe, paused, pd, in_rst;
  logic dl3, dl3_oe; // Shared pin drive value and enable
  logic [63:0] rx; // Bits sampled by the host in the last frame
  logic [7:0] v; // Last register value read
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0; // Hang guard
  // Direct commands and values that avoid live and role bits
  logic [7:0] wc [3] = '{CMD_WR_SR1, CMD_WR_SR2, CMD_WR_SR3};
  logic [7:0] rc [3] = '{CMD_RD_SR1, CMD_RD_SR2, CMD_RD_SR3};
  logic [7:0] val [3] = '{8'h0C, 8'h44, 8'h25};
  int lens [3] = '{40, 41, 42};

  always #12.5 clk_i = ~clk_i;

  fsr_core fsr_core_inst (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .si_i(si), .hold_reset_n_i(pin_n),
    .data_line_three_o(dl3), .data_line_three_oe_o(dl3_oe), .so_o(so),
    .so_oe_o(so_oe), .paused_o(paused), .power_down_o(pd),
    .in_reset_o(in_rst));

  fsr_host fsr_host_inst (.clk_i(clk_i), .so_i(so), .so_oe_i(so_oe),
    .paused_i(paused), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si),
    .pin_n_o(pin_n));

  // Compare one byte and count it
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Enable frame, then a write frame of n bits taken from body
  task automatic wr(input logic [7:0] en, input logic [23:0] body,
                    input int n);
    fsr_host_inst.frame({56'h0, en}, 8, 0, rx);
    fsr_host_inst.frame(64'(body >> (24 - n)), n, 0, rx);
    if (en == CMD_WREN) begin
      // Stored-copy write keeps the device busy for a while
      fsr_host_inst.tick(100);
    end
  endtask : wr
  // Read frame: header then one answer byte, optional pause
  task automatic rd(input logic [15:0] hdr, input int n, input int p);
    fsr_host_inst.frame(64'({hdr, 8'h00} >> (24 - n)), n, p, rx);
    v = rx[7:0];
  endtask : rd
  // Verdict, reached from the main sequence or the hang guard
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  // Whole run needs roughly 9k cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    repeat (4) @(posedge clk_i);
    #1 rst_i = 1'b0;
    fsr_host_inst.tick(6);
    // Power-up contents come from the stored copy
    for (int a = 1; a <= 5; a++) begin
      rd({CMD_RD_IND, 8'(a)}, 24, 0);
      check(v, NV_DEFAULT[8*a-8 +: 8]);
    end
    // Direct write then direct and indirect read of registers one..three
    for (int i = 0; i < 3; i++) begin
      wr(CMD_VWREN, {wc[i], val[i], 8'h00}, 16);
      rd({rc[i], 8'h00}, 16, 0);
      check(v, val[i]);
      rd({CMD_RD_IND, 8'(i + 1)}, 24, 0);
      check(v, val[i]);
    end
    // Registers four and five only by address
    wr(CMD_VWREN, {CMD_WR_IND, ADDR_SR_FOUR, 8'hA5}, 24);
    wr(CMD_WREN, {CMD_WR_IND, ADDR_SR_FIVE, 8'h3C}, 24);
    rd({CMD_RD_IND, ADDR_SR_FOUR}, 24, 0);
    check(v, 8'hA5);
    rd({CMD_RD_IND, ADDR_SR_FIVE}, 24, 0);
    check(v, 8'h3C);
    // Address past the last register: no write, reads zero
    wr(CMD_VWREN, {CMD_WR_IND, 8'h06, 8'hFF}, 24);
    rd({CMD_RD_IND, 8'h06}, 24, 0);
    check(v, 8'h00);
    rd({CMD_RD_IND, ADDR_SR_FOUR}, 24, 0);
    check(v, 8'hA5);
    // Write on 17 clocks dropped; whole write then uses up the enable
    wr(CMD_VWREN, {CMD_WR_SR3, 8'h11, 8'h00}, 17);
    fsr_host_inst.frame({48'h0, CMD_WR_SR3, 8'h25}, 16, 0, rx);
    // Enable on 9 clocks dropped, so the next write is refused
    fsr_host_inst.frame({55'h0, CMD_VWREN, 1'b0}, 9, 0, rx);
    fsr_host_inst.frame({48'h0, CMD_WR_SR3, 8'h11}, 16, 0, rx);
    rd({CMD_RD_SR3, 8'h00}, 16, 0);
    check(v, 8'h25);
    // Pause in the answer byte, then inside the command byte
    rd({CMD_RD_IND, ADDR_SR_FOUR}, 24, 20);
    check(v, 8'hA5);
    check({7'h00, fsr_host_inst.pause_seen}, 8'h01);
    rd({CMD_RD_SR2, 8'h00}, 16, 4);
    check(v, 8'h44);
    check({7'h00, fsr_host_inst.pause_seen}, 8'h01);
    // Reset role set in flip-flops only; pin reset restores stored copy
    wr(CMD_VWREN, {CMD_WR_SR3, 8'hA5, 8'h00}, 16);
    fsr_host_inst.set_pin(1'b0);
    check({7'h00, in_rst}, 8'h01);
    rd({CMD_RD_SR3, 8'h00}, 16, 0);
    check({7'h00, fsr_host_inst.oe_seen}, 8'h00);
    fsr_host_inst.set_pin(1'b1);
    rd({CMD_RD_SR3, 8'h00}, 16, 0);
    check(v, NV_DEFAULT[23:16]);
    // Reset role through both copies survives a pin reset
    wr(CMD_WREN, {CMD_WR_SR3, 8'h80, 8'h00}, 16);
    fsr_host_inst.set_pin(1'b0);
    check({7'h00, in_rst}, 8'h01);
    fsr_host_inst.set_pin(1'b1);
    rd({CMD_RD_SR3, 8'h00}, 16, 0);
    check(v, 8'h80);
    // Quad enable takes the pin away from the reset role
    wr(CMD_WREN, {CMD_WR_SR2, 8'h02, 8'h00}, 16);
    fsr_host_inst.set_pin(1'b0);
    check({7'h00, in_rst}, 8'h00);
    check({6'h00, dl3, dl3_oe}, 8'h00);
    fsr_host_inst.set_pin(1'b1);
    // Power-down exit needs exactly one whole byte, or five or more whole bytes for an id read
    fsr_host_inst.frame({56'h0, CMD_PD_ENTER}, 8, 0, rx);
    fsr_host_inst.frame({55'h0, CMD_PD_EXIT, 1'b0}, 9, 0, rx);
    check({7'h00, pd}, 8'h01);
    fsr_host_inst.frame({54'h0, CMD_PD_EXIT, 2'b00}, 10, 0, rx);
    check({7'h00, pd}, 8'h01);
    fsr_host_inst.frame({56'h0, CMD_PD_EXIT}, 8, 0, rx);
    check({7'h00, pd}, 8'h00);
    // Identifier read ending on clock 40, 41 and 42
    for (int k = 0; k < 3; k++) begin
      fsr_host_inst.frame({56'h0, CMD_PD_ENTER}, 8, 0, rx);
      fsr_host_inst.frame({24'h0, CMD_PD_EXIT, 32'h0} << (lens[k] - 40),
                          lens[k], 0, rx);
      check(8'(rx >> (lens[k] - 40)), ID_CODE);
      check({7'h00, pd}, (k == 0) ? 8'h00 : 8'h01);
    end
    stop_test();
  end
endmodule : tb_flash_spi_frame_hold_status_access
